/* tb_uart_host_transport_port.sv */
`timescale 1ns/1ps
module tb_uart_host_transport_port
	import uhtp_pkg::*;
();
	localparam int BIT_CYC = CLK_HZ / BAUD_MAX;
	logic clock = 1'b0;
	logic reset = 1'b1;
	logic [2:0] opt, sc;
	logic sv, rsave, lup, cfg_load, cfg_flow, cfg_stop2, low_power, host_wakeup, wakeup;
	uhtp_div_t rdiv;
	uhtp_parity_t cfg_par;
	logic [7:0] txd, rxd, reg_addr, reg_wdata, reg_rdata;
	logic txv, txr, rxv, rxr, perr, ferr, ovr, reg_wr, reg_rd, rd_d;
	logic [15:0] note;
	int n_errors = 0;
	int checks = 0;
	logic [15:0] exp_q[$];
	logic [7:0] rx_q[$];
	int rates[8] = '{0, 2400, 9600, 19200, 38400, 57600, 115200, 921600};

	// Free running system clock
	always #10 clock = ~clock;

	uhtp_link_if u_uhtp_link_if ();
	uhtp_dev_end u_uhtp_dev_end (.clock(clock), .reset(reset), .link(u_uhtp_link_if),
		.option_pin_a(opt[0]), .option_pin_b(opt[1]), .option_pin_c(opt[2]),
		.param_store_valid(sv), .param_store_code(sc), .rate_save(rsave), .rate_div(rdiv),
		.link_up(lup), .cfg_load(cfg_load), .cfg_flow(cfg_flow), .cfg_parity(cfg_par),
		.cfg_stop2(cfg_stop2), .low_power(low_power), .host_wakeup(host_wakeup), .wakeup(wakeup),
		.tx_dma_data(txd), .tx_dma_valid(txv), .tx_dma_ready(txr), .rx_dma_data(rxd),
		.rx_dma_valid(rxv), .rx_dma_ready(rxr), .rx_parity_err(perr), .rx_frame_err(ferr),
		.rx_overrun(ovr));
	uhtp_host_end u_uhtp_host_end (.clock(clock), .reset(reset), .link(u_uhtp_link_if),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata));
	uhtp_link_monitor u_uhtp_link_monitor (.clock(clock), .reset(reset),
		.host_to_dev(u_uhtp_link_if.host_to_dev), .dev_to_host(u_uhtp_link_if.dev_to_host),
		.dev_rts_n(u_uhtp_link_if.dev_rts_n), .host_rts_n(u_uhtp_link_if.host_rts_n));

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : tally_and_finish

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic cyc(input int k);
		repeat (k) @(posedge clock);
		@(negedge clock);
	endtask : cyc

	task automatic rst(input logic [2:0] c, input logic s, input logic [2:0] sc_i);
		@(posedge clock);
		reset <= 1'b1;
		opt <= c;
		sv <= s;
		sc <= sc_i;
		repeat (20) @(posedge clock);
		reset <= 1'b0;
	endtask : rst

	// One-cycle load of the device line settings
	task automatic load_cfg(input logic fl, input uhtp_parity_t p, input logic s2);
		@(posedge clock);
		cfg_load <= 1'b1;
		cfg_flow <= fl;
		cfg_par <= p;
		cfg_stop2 <= s2;
		@(posedge clock);
		cfg_load <= 1'b0;
	endtask : load_cfg

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m, output logic [7:0] v);
		@(posedge clock);
		reg_rd <= 1'b1;
		reg_addr <= a;
		exp_q.push_back({m, e});
		@(posedge clock);
		reg_rd <= 1'b0;
		@(negedge clock);
		v = reg_rdata;
	endtask : rd

	task automatic dev_send(input logic [7:0] b);
		@(posedge clock);
		txd <= b;
		txv <= 1'b1;
		@(negedge clock);
		while (txr !== 1'b1)
			@(negedge clock);
		@(posedge clock);
		txv <= 1'b0;
	endtask : dev_send

	task automatic wait_rts();
		int w;
		w = 0;
		while (u_uhtp_link_if.host_rts_n !== 1'b1 && w < 3000) begin
			@(negedge clock);
			w++;
		end
	endtask : wait_rts

	// Samples each device bit in mid period against the expected frame
	task automatic line_chk(input logic [7:0] b, input int par, input int s2);
		logic [11:0] f;
		f = (par == 0) ? {3'b111, b, 1'b0} : {2'b11, (^b) ^ (par == 1), b, 1'b0};
		@(negedge u_uhtp_link_if.dev_to_host);
		repeat (BIT_CYC / 2) @(posedge clock);
		for (int i = 0; i < 10 + (par != 0) + s2; i++) begin
			#1 chk(u_uhtp_link_if.dev_to_host, f[i]);
			repeat (BIT_CYC) @(posedge clock);
		end
	endtask : line_chk

	// Compares read data and received bytes with the oldest notes
	always @(posedge clock)
		rd_d <= reg_rd;
	always @(negedge clock) begin
		if (rd_d && exp_q.size() > 0) begin
			note = exp_q.pop_front();
			if (note[15:8] != 8'h00)
				chk(reg_rdata & note[15:8], note[7:0]);
		end
		if (rxv === 1'b1 && rxr === 1'b1)
			chk(rxd, (rx_q.size() > 0) ? 16'(rx_q.pop_front()) : 16'hffff);
		// No scenario sends a bad or lost character
		if ({perr, ferr, ovr} !== 3'h0)
			chk(16'({perr, ferr, ovr}), 16'h0000);
	end

	// Watchdog
	initial begin
		repeat (90000) @(posedge clock);
		n_errors++;
		tally_and_finish();
	end

	initial begin
		logic [7:0] v, b0, b1, h;
		int n, t;
		{opt, sv, sc, cfg_load, cfg_flow, cfg_stop2, low_power, host_wakeup, txv, reg_wr, reg_rd} <= '0;
		{txd, reg_addr, reg_wdata} <= '0;
		cfg_par <= PAR_NONE;
		rxr <= 1'b1;
		void'($urandom(32'h1423fa9b));
		// Rate from straps, or from the store when straps ask for detection
		for (int c = 0; c < 8; c++) begin
			rst(3'(c), 1'b1, 3'h3);
			cyc(3);
			chk(rdiv, 16'(CLK_HZ / rates[(c != 0) ? c : 3]));
			chk(lup, 1'b1);
		end
		// Rate detection from a host reference character
		rst(3'h0, 1'b0, 3'h0);
		cyc(3);
		chk(lup, 1'b0);
		wr(REG_CTRL, 8'h07);
		wr(REG_TXDATA, 8'hff);
		for (n = 0; rsave !== 1'b1 && n < 3000; n++)
			@(negedge clock);
		chk(rsave, 1'b1);
		chk(rdiv, 16'(BIT_CYC));
		// Both directions in every line format
		rst(3'h7, 1'b0, 3'h0);
		rd(REG_CTRL, CTRL_RESET, 8'hff, v);
		rd(8'h10, 8'h00, 8'hff, v);
		for (int k = 0; k < 6; k++) begin
			b0 = 8'($urandom);
			b1 = 8'($urandom);
			h = 8'($urandom);
			load_cfg(1'b1, uhtp_parity_t'(k % 3), 1'(k >= 3));
			wr(REG_CTRL, 8'h47 | (8'(k % 3) << 3) | (8'(k / 3) << 5));
			rx_q.push_back(h);
			// Second byte waits in the background until the host reads the first
			fork
				begin
					dev_send(b0);
					dev_send(b1);
				end
			join_none
			fork
				line_chk(b0, k % 3, k / 3);
				wr(REG_TXDATA, h);
			join
			wait_rts();
			cyc(700);
			rd(REG_RXDATA, b0, 8'hff, v);
			wait_rts();
			rd(REG_RXDATA, b1, 8'hff, v);
			rd(REG_STATUS, 8'h00, 8'h0c, v);
			cyc(120);
		end
		// Fill the receive buffer while its reader stalls
		@(posedge clock);
		rxr <= 1'b0;
		n = 0;
		for (int i = 0; i < 40; i++) begin
			t = 0;
			do
				rd(REG_STATUS, 8'h00, 8'h00, v);
			while (v[ST_TX_BUSY] === 1'b1 && ++t < 400);
			if (v[ST_TX_BUSY] !== 1'b0)
				break;
			h = 8'($urandom);
			wr(REG_TXDATA, h);
			rx_q.push_back(h);
			n++;
		end
		wr(REG_TXDATA, 8'h5a);
		chk(16'(n), 16'(FIFO_DEPTH - FIFO_MARGIN + 1));
		chk(u_uhtp_link_if.dev_rts_n, 1'b1);
		// Flow off keeps the ready line low even with the buffer filled past its margin
		load_cfg(1'b0, PAR_EVEN, 1'b1);
		cyc(2);
		chk(u_uhtp_link_if.dev_rts_n, 1'b0);
		load_cfg(1'b1, PAR_EVEN, 1'b1);
		cyc(2);
		chk(u_uhtp_link_if.dev_rts_n, 1'b1);
		// Drain with random reader stalls
		for (t = 0; t < 40000 && rx_q.size() > 0; t++) begin
			@(posedge clock);
			rxr <= 1'($urandom);
		end
		@(posedge clock);
		rxr <= 1'b1;
		cyc(60);
		chk(16'(rx_q.size()), 16'h0000);
		chk(u_uhtp_link_if.dev_rts_n, 1'b0);
		// Wakeup signalling in low power
		@(posedge clock);
		low_power <= 1'b1;
		host_wakeup <= 1'b1;
		cyc(4);
		chk(u_uhtp_link_if.dev_rts_n, 1'b0);
		chk(wakeup, 1'b1);
		@(posedge clock);
		host_wakeup <= 1'b0;
		cyc(4);
		chk(u_uhtp_link_if.dev_rts_n, 1'b1);
		@(posedge clock);
		low_power <= 1'b0;
		cyc(700);
		chk(wakeup, 1'b0);
		// Host ready line with a byte unread: two-wire tie, then wakeup request
		dev_send(8'h3c);
		wait_rts();
		wr(REG_CTRL, 8'h37);
		cyc(1);
		chk(u_uhtp_link_if.host_rts_n, 1'b0);
		wr(REG_CTRL, 8'hf7);
		cyc(1);
		chk(u_uhtp_link_if.host_rts_n, 1'b0);
		rd(REG_RXDATA, 8'h3c, 8'hff, v);
		tally_and_finish();
	end
endmodule : tb_uart_host_transport_port

/* uhtp_dev_end.sv */
`timescale 1ns/1ps
module uhtp_dev_end
	import uhtp_pkg::*;
(
	// Clock and reset
	input  wire logic         clock,
	input  wire logic         reset,
	// Serial link
	uhtp_link_if.dev          link,
	// Startup straps and stored rate
	input  wire logic         option_pin_a,
	input  wire logic         option_pin_b,
	input  wire logic         option_pin_c,
	input  wire logic         param_store_valid,
	input  wire logic [2:0]   param_store_code,
	output logic              rate_save,
	output uhtp_div_t         rate_div,
	output logic              link_up,
	// Line configuration
	input  wire logic         cfg_load,
	input  wire logic         cfg_flow,
	input  wire uhtp_parity_t cfg_parity,
	input  wire logic         cfg_stop2,
	// Power management
	input  wire logic         low_power,
	input  wire logic         host_wakeup,
	output logic              wakeup,
	// Transmit stream
	input  wire logic [7:0]   tx_dma_data,
	input  wire logic         tx_dma_valid,
	output logic              tx_dma_ready,
	// Receive stream
	output logic [7:0]        rx_dma_data,
	output logic              rx_dma_valid,
	input  wire logic         rx_dma_ready,
	// Receive errors
	output logic              rx_parity_err,
	output logic              rx_frame_err,
	output logic              rx_overrun
);
	typedef enum logic [1:0] {BOOT_SAMPLE, BOOT_WAIT_REF, BOOT_MEASURE, BOOT_RUN} uhtp_boot_t;

	typedef struct packed {
		uhtp_boot_t   boot;
		uhtp_div_t    div;
		logic         save;
		logic         flow;
		uhtp_parity_t par;
		logic         stop2;
		uhtp_frame_t  tx_sh;
		logic [3:0]   tx_left;
		uhtp_div_t    tx_cnt;
		uhtp_frame_t  rx_sh;
		logic [3:0]   rx_left;
		uhtp_div_t    rx_cnt;
		logic         push_valid;
		logic [7:0]   push_data;
		logic         perr;
		logic         ferr;
		logic         overrun;
		logic         tx_line;
		logic         rts_n;
		logic         wake;
	} uhtp_dev_state_t;

	localparam uhtp_dev_state_t DEV_RESET = '{
		boot:    BOOT_SAMPLE,
		flow:    FLOW_RESET,
		par:     PAR_RESET,
		stop2:   STOP2_RESET,
		tx_line: 1'b1,
		rts_n:   1'b1,
		default: '0
	};

	uhtp_dev_state_t              state_reg;
	uhtp_dev_state_t              state_next;
	logic                         fifo_in_ready;
	logic [$clog2(FIFO_DEPTH):0]  fifo_level;
	logic                         running;

	// Receive buffer between the line and the drain stream
	uhtp_fifo #(
		.WIDTH (DATA_BITS),
		.DEPTH (FIFO_DEPTH)
	) rx_fifo (
		.clock     (clock),
		.reset     (reset),
		.in_data   (state_reg.push_data),
		.in_valid  (state_reg.push_valid),
		.in_ready  (fifo_in_ready),
		.out_data  (rx_dma_data),
		.out_valid (rx_dma_valid),
		.out_ready (rx_dma_ready),
		.level     (fifo_level)
	);

	// Transmit accepts a byte only when running, idle and out of low power, and, with handshaking on, when the host is ready
	assign running      = state_reg.boot == BOOT_RUN;
	assign tx_dma_ready = running && (state_reg.tx_left == '0) && !low_power
		&& (!state_reg.flow || !link.host_rts_n);

	// Outputs
	assign link.dev_to_host = state_reg.tx_line;
	assign link.dev_rts_n   = state_reg.rts_n;
	assign rate_div         = state_reg.div;
	assign rate_save        = state_reg.save;
	assign link_up          = running;
	assign wakeup           = state_reg.wake;
	assign rx_parity_err    = state_reg.perr;
	assign rx_frame_err     = state_reg.ferr;
	assign rx_overrun       = state_reg.overrun;

	// Next state
	always_comb begin
		logic [2:0]  opt;
		logic [3:0]  len;
		uhtp_frame_t f;
		opt = {option_pin_c, option_pin_b, option_pin_a};
		len = frame_len(state_reg.par, state_reg.stop2);
		f = '0;
		state_next = state_reg;
		state_next.save = 1'b0;
		state_next.push_valid = 1'b0;
		state_next.perr = 1'b0;
		state_next.ferr = 1'b0;
		// A byte offered to a full buffer is lost
		state_next.overrun = state_reg.push_valid & ~fifo_in_ready;

		// Startup rate selection
		unique case (state_reg.boot)
			BOOT_SAMPLE: begin
				if (opt != OPT_AUTO) begin
					state_next.div = baud_div(opt);
					state_next.boot = BOOT_RUN;
				end else if (param_store_valid && (param_store_code != OPT_AUTO)) begin
					state_next.div = baud_div(param_store_code);
					state_next.boot = BOOT_RUN;
				end else begin
					state_next.boot = BOOT_WAIT_REF;
				end
			end
			BOOT_WAIT_REF: begin
				if (!link.host_to_dev) begin
					state_next.div = 16'h0001;
					state_next.boot = BOOT_MEASURE;
				end
			end
			BOOT_MEASURE: begin
				// Length of the first low pulse is one bit period
				if (!link.host_to_dev) begin
					if (state_reg.div != '1)
						state_next.div = state_reg.div + 1'b1;
				end else begin
					state_next.boot = BOOT_RUN;
					state_next.save = 1'b1;
				end
			end
			BOOT_RUN: begin
			end
		endcase

		// Line settings, handshaking on until changed
		if (cfg_load) begin
			state_next.flow = cfg_flow;
			state_next.par = cfg_parity;
			state_next.stop2 = cfg_stop2;
		end

		// Transmit shifter, one bit per divider period
		if (tx_dma_ready && tx_dma_valid) begin
			state_next.tx_sh = build_frame(tx_dma_data, state_reg.par);
			state_next.tx_left = len;
			state_next.tx_cnt = state_reg.div;
		end else if (state_reg.tx_left != '0) begin
			if (state_reg.tx_cnt == 16'h0001) begin
				state_next.tx_cnt = state_reg.div;
				state_next.tx_sh = {1'b1, state_reg.tx_sh[FRAME_MAX-1:1]};
				state_next.tx_left = state_reg.tx_left - 1'b1;
			end else begin
				state_next.tx_cnt = state_reg.tx_cnt - 1'b1;
			end
		end
		// Idle line is high
		state_next.tx_line = (state_next.tx_left != '0) ? state_next.tx_sh[0] : 1'b1;

		// Receive shifter, sampling mid-bit from the start edge
		if (state_reg.rx_left == '0) begin
			if (running && !link.host_to_dev) begin
				state_next.rx_left = len;
				state_next.rx_cnt = half_div(state_reg.div);
			end
		end else if (state_reg.rx_cnt == 16'h0001) begin
			state_next.rx_cnt = state_reg.div;
			state_next.rx_sh = {link.host_to_dev, state_reg.rx_sh[FRAME_MAX-1:1]};
			state_next.rx_left = state_reg.rx_left - 1'b1;
			if (state_reg.rx_left == 4'h1) begin
				f = align(state_next.rx_sh, len);
				state_next.push_valid = 1'b1;
				state_next.push_data = f[DATA_BITS:1];
				state_next.perr = parity_bad(f, state_reg.par);
				state_next.ferr = frame_bad(f, state_reg.par, state_reg.stop2);
			end
		end else begin
			state_next.rx_cnt = state_reg.rx_cnt - 1'b1;
		end

		// Ready-to-receive line, or host wakeup in low power
		if (low_power)
			state_next.rts_n = ~host_wakeup;
		else if (!state_next.flow)
			state_next.rts_n = 1'b0;
		else
			state_next.rts_n = !running
				|| (fifo_level >= 6'(FIFO_DEPTH - FIFO_MARGIN));

		// Clear-to-send low or line activity wakes the device
		state_next.wake = low_power & (~link.host_rts_n | ~link.host_to_dev);
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset)
			state_reg <= DEV_RESET;
		else
			state_reg <= state_next;
	end
endmodule : uhtp_dev_end

/* uhtp_fifo.sv */
`timescale 1ns/1ps
module uhtp_fifo
	import uhtp_pkg::*;
#(
	parameter int WIDTH = DATA_BITS,
	parameter int DEPTH = FIFO_DEPTH
)
(
	// Clock and reset
	input  wire logic                   clock,
	input  wire logic                   reset,
	// Fill side
	input  wire logic [WIDTH-1:0]       in_data,
	input  wire logic                   in_valid,
	output logic                        in_ready,
	// Drain side
	output logic [WIDTH-1:0]            out_data,
	output logic                        out_valid,
	input  wire logic                   out_ready,
	// Fill level
	output logic [$clog2(DEPTH):0]      level
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [AW:0] wr_ptr;
		logic [AW:0] rd_ptr;
	} uhtp_fifo_state_t;

	uhtp_fifo_state_t state_reg;
	uhtp_fifo_state_t state_next;
	logic [WIDTH-1:0] mem [DEPTH];
	logic             push;
	logic             pop;

	// Occupancy and handshakes
	assign level     = state_reg.wr_ptr - state_reg.rd_ptr;
	assign in_ready  = level != (AW+1)'(DEPTH);
	assign out_valid = level != '0;
	assign out_data  = mem[state_reg.rd_ptr[AW-1:0]];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	// Pointer update
	always_comb begin
		state_next = state_reg;
		if (push)
			state_next.wr_ptr = state_reg.wr_ptr + 1'b1;
		if (pop)
			state_next.rd_ptr = state_reg.rd_ptr + 1'b1;
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset)
			state_reg <= '0;
		else
			state_reg <= state_next;
	end

	// Storage
	always_ff @(posedge clock) begin
		if (push)
			mem[state_reg.wr_ptr[AW-1:0]] <= in_data;
	end
endmodule : uhtp_fifo

/* uhtp_host_end.sv */
`timescale 1ns/1ps
module uhtp_host_end
	import uhtp_pkg::*;
(
	// Clock and reset
	input  wire logic       clock,
	input  wire logic       reset,
	// Serial link
	uhtp_link_if.host       link,
	// Register port
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic [7:0]      reg_rdata
);
	typedef struct packed {
		logic [7:0]  ctrl;
		logic [7:0]  rdata;
		logic [7:0]  hold;
		logic        hold_full;
		uhtp_frame_t tx_sh;
		logic [3:0]  tx_left;
		uhtp_div_t   tx_cnt;
		uhtp_frame_t rx_sh;
		logic [3:0]  rx_left;
		uhtp_div_t   rx_cnt;
		logic [7:0]  rx_data;
		logic        rx_valid;
		logic        perr;
		logic        ferr;
		logic        tx_line;
		logic        rts_n;
	} uhtp_host_state_t;

	localparam uhtp_host_state_t HOST_RESET = '{
		ctrl: CTRL_RESET, tx_line: 1'b1, rts_n: 1'b1, default: '0
	};

	uhtp_host_state_t state_reg;
	uhtp_host_state_t state_next;

	assign link.host_to_dev = state_reg.tx_line;
	assign link.host_rts_n  = state_reg.rts_n;
	assign reg_rdata        = state_reg.rdata;

	// Next state
	always_comb begin
		uhtp_parity_t par;
		logic         stop2;
		logic         flow;
		uhtp_div_t    div;
		logic [3:0]   len;
		logic [7:0]   st;
		uhtp_frame_t  f;
		par = uhtp_parity_t'(state_reg.ctrl[CTRL_PAR +: 2]);
		stop2 = state_reg.ctrl[CTRL_STOP2];
		flow = state_reg.ctrl[CTRL_FLOW];
		div = baud_div(state_reg.ctrl[CTRL_BAUD +: 3]);
		len = frame_len(par, stop2);
		st = '0;
		st[ST_TX_BUSY] = state_reg.hold_full | (state_reg.tx_left != '0);
		st[ST_RX_VALID] = state_reg.rx_valid;
		st[ST_PAR_ERR] = state_reg.perr;
		st[ST_FRM_ERR] = state_reg.ferr;
		st[ST_PEER_RTS] = ~link.dev_rts_n;
		f = '0;
		state_next = state_reg;

		// Register reads; data stand for one cycle only
		state_next.rdata = '0;
		if (reg_rd) begin
			case (reg_addr)
				REG_CTRL: state_next.rdata = state_reg.ctrl;
				REG_STATUS: begin
					state_next.rdata = st;
					state_next.perr = 1'b0;
					state_next.ferr = 1'b0;
				end
				REG_RXDATA: begin
					state_next.rdata = state_reg.rx_data;
					state_next.rx_valid = 1'b0;
				end
				default: state_next.rdata = '0;
			endcase
		end

		// Register writes; a byte written while the holding register is full is dropped
		if (reg_wr) begin
			case (reg_addr)
				REG_CTRL: state_next.ctrl = reg_wdata;
				REG_TXDATA: begin
					if (!state_reg.hold_full) begin
						state_next.hold = reg_wdata;
						state_next.hold_full = 1'b1;
					end
				end
				default: begin
				end
			endcase
		end

		// Transmit, held off while handshaking is on and the device is not ready
		if (state_reg.hold_full && (state_reg.tx_left == '0) && (!flow || !link.dev_rts_n)) begin
			state_next.tx_sh = build_frame(state_reg.hold, par);
			state_next.tx_left = len;
			state_next.tx_cnt = div;
			state_next.hold_full = 1'b0;
		end else if (state_reg.tx_left != '0) begin
			if (state_reg.tx_cnt == 16'h0001) begin
				state_next.tx_cnt = div;
				state_next.tx_sh = {1'b1, state_reg.tx_sh[FRAME_MAX-1:1]};
				state_next.tx_left = state_reg.tx_left - 1'b1;
			end else begin
				state_next.tx_cnt = state_reg.tx_cnt - 1'b1;
			end
		end
		state_next.tx_line = (state_next.tx_left != '0) ? state_next.tx_sh[0] : 1'b1;

		// Receive; a new character wins over a clear in the same cycle
		if (state_reg.rx_left == '0) begin
			if (!link.dev_to_host) begin
				state_next.rx_left = len;
				state_next.rx_cnt = half_div(div);
			end
		end else if (state_reg.rx_cnt == 16'h0001) begin
			state_next.rx_cnt = div;
			state_next.rx_sh = {link.dev_to_host, state_reg.rx_sh[FRAME_MAX-1:1]};
			state_next.rx_left = state_reg.rx_left - 1'b1;
			if (state_reg.rx_left == 4'h1) begin
				f = align(state_next.rx_sh, len);
				state_next.rx_data = f[DATA_BITS:1];
				state_next.rx_valid = 1'b1;
				state_next.perr = state_next.perr | parity_bad(f, par);
				state_next.ferr = state_next.ferr | frame_bad(f, par, stop2);
			end
		end else begin
			state_next.rx_cnt = state_reg.rx_cnt - 1'b1;
		end

		// Wakeup request, else ready flag, else tied low for two wires
		if (state_next.ctrl[CTRL_WAKE])
			state_next.rts_n = 1'b0;
		else if (state_next.ctrl[CTRL_FLOW])
			state_next.rts_n = state_next.rx_valid;
		else
			state_next.rts_n = 1'b0;
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset)
			state_reg <= HOST_RESET;
		else
			state_reg <= state_next;
	end
endmodule : uhtp_host_end

/* uhtp_link_if.sv */
`timescale 1ns/1ps
interface uhtp_link_if;
	logic host_to_dev;  // Serial data, host to device
	logic dev_to_host;  // Serial data, device to host
	logic dev_rts_n;    // Device ready to receive, host clear to send
	logic host_rts_n;   // Host ready to receive, device clear to send
	modport dev (input host_to_dev, host_rts_n, output dev_to_host, dev_rts_n);
	modport host (input dev_to_host, dev_rts_n, output host_to_dev, host_rts_n);
endinterface : uhtp_link_if

/* uhtp_link_monitor.sv */
`timescale 1ns/1ps
module uhtp_link_monitor
	import uhtp_pkg::*;
(
	// Clock and reset
	input  wire logic clock,
	input  wire logic reset,
	// Link lines
	input  wire logic host_to_dev,
	input  wire logic dev_to_host,
	input  wire logic dev_rts_n,
	input  wire logic host_rts_n
);
	localparam int BIT_CYC = CLK_HZ / BAUD_MAX;
	logic [9:0] tl_cnt, th_cnt, rl_cnt, rh_cnt;
	logic [3:0] hr_cnt;

	// Run lengths of each data line level and of host_rts_n high, saturating
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			tl_cnt <= '0;
			rl_cnt <= '0;
			hr_cnt <= '0;
			th_cnt <= '1;
			rh_cnt <= '1;
		end else begin
			tl_cnt <= dev_to_host ? '0 : tl_cnt + 10'(tl_cnt != '1);
			th_cnt <= !dev_to_host ? '0 : th_cnt + 10'(th_cnt != '1);
			rl_cnt <= host_to_dev ? '0 : rl_cnt + 10'(rl_cnt != '1);
			rh_cnt <= !host_to_dev ? '0 : rh_cnt + 10'(rh_cnt != '1);
			hr_cnt <= !host_rts_n ? '0 : hr_cnt + 4'(hr_cnt != '1);
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);

	a_reset_idle: assert property (
		$fell(reset) |-> dev_to_host && host_to_dev && dev_rts_n && host_rts_n)
		else $error("link not idle at reset release");
	a_flow_default: assert property (
		$fell(reset) |-> ##[1:3] !host_rts_n)
		else $error("host ready not raised after reset");
	a_tx_bit_width: assert property (
		$rose(dev_to_host) |-> (tl_cnt % BIT_CYC) == 0)
		else $error("device low run not whole bits");
	a_tx_low_bound: assert property (
		$rose(dev_to_host) |-> tl_cnt <= 10 * BIT_CYC)
		else $error("device low run too long");
	a_tx_high_run: assert property (
		$fell(dev_to_host) |-> th_cnt >= BIT_CYC)
		else $error("device high run short");
	a_rx_bit_width: assert property (
		$rose(host_to_dev) |-> (rl_cnt % BIT_CYC) == 0)
		else $error("host low run not whole bits");
	a_rx_high_run: assert property (
		$fell(host_to_dev) |-> rh_cnt >= BIT_CYC)
		else $error("host high run short");
	a_cts_blocks: assert property (
		$fell(dev_to_host) |-> hr_cnt < 8)
		else $error("device sent while host not ready");
endmodule : uhtp_link_monitor

/* uhtp_pkg.sv */
package uhtp_pkg;
	// Clock and frame geometry
	localparam int CLK_HZ      = 50_000_000;
	localparam int DATA_BITS   = 8;
	localparam int FRAME_MAX   = 12;
	localparam int FIFO_DEPTH  = 32;
	localparam int FIFO_MARGIN = 4;

	// Rate limits in bit/s
	localparam int BAUD_MIN = 2400;
	localparam int BAUD_MAX = 921_600;

	// Option code that selects rate detection
	localparam logic [2:0] OPT_AUTO = 3'h0;

	// Power-up line settings
	localparam logic FLOW_RESET  = 1'b1;
	localparam logic STOP2_RESET = 1'b0;

	// Host controller register map
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_TXDATA = 8'h08;
	localparam logic [7:0] REG_RXDATA = 8'h0c;

	// Control fields
	localparam int CTRL_BAUD  = 0;
	localparam int CTRL_PAR   = 3;
	localparam int CTRL_STOP2 = 5;
	localparam int CTRL_FLOW  = 6;
	localparam int CTRL_WAKE  = 7;
	localparam logic [7:0] CTRL_RESET = 8'h47;

	// Status fields
	localparam int ST_TX_BUSY  = 0;
	localparam int ST_RX_VALID = 1;
	localparam int ST_PAR_ERR  = 2;
	localparam int ST_FRM_ERR  = 3;
	localparam int ST_PEER_RTS = 4;

	typedef enum logic [1:0] {PAR_NONE, PAR_ODD, PAR_EVEN} uhtp_parity_t;
	localparam uhtp_parity_t PAR_RESET = PAR_NONE;
	typedef logic [15:0] uhtp_div_t;
	typedef logic [FRAME_MAX-1:0] uhtp_frame_t;

	// Bit period in clock cycles for a rate code
	function automatic uhtp_div_t baud_div(input logic [2:0] code);
		int rate;
		case (code)
			3'h2: rate = 9600;
			3'h3: rate = 19200;
			3'h4: rate = 38400;
			3'h5: rate = 57600;
			3'h6: rate = 115200;
			3'h7: rate = BAUD_MAX;
			default: rate = BAUD_MIN;
		endcase
		return uhtp_div_t'(CLK_HZ / rate);
	endfunction : baud_div

	// Half a bit period, never zero
	function automatic uhtp_div_t half_div(input uhtp_div_t div);
		return (div < 16'h0002) ? 16'h0001 : (div >> 1);
	endfunction : half_div

	// Bits in one character, start to last stop
	function automatic logic [3:0] frame_len(input uhtp_parity_t par, input logic stop2);
		return 4'(2 + DATA_BITS + int'(par != PAR_NONE) + int'(stop2));
	endfunction : frame_len

	function automatic logic par_bit(input logic [7:0] d, input uhtp_parity_t par);
		return (^d) ^ (par == PAR_ODD);
	endfunction : par_bit

	// Character laid out LSB first, idle ones above
	function automatic uhtp_frame_t build_frame(input logic [7:0] d, input uhtp_parity_t par);
		uhtp_frame_t f;
		f = '1;
		f[0] = 1'b0;
		f[DATA_BITS:1] = d;
		if (par != PAR_NONE)
			f[DATA_BITS+1] = par_bit(d, par);
		return f;
	endfunction : build_frame

	// Received bits enter at the top; move them down to bit 0
	function automatic uhtp_frame_t align(input uhtp_frame_t sh, input logic [3:0] len);
		return uhtp_frame_t'(sh >> (FRAME_MAX - int'(len)));
	endfunction : align

	function automatic logic frame_bad(input uhtp_frame_t f, input uhtp_parity_t par, input logic stop2);
		int p;
		p = DATA_BITS + 1 + int'(par != PAR_NONE);
		return f[0] | ~f[p] | (stop2 & ~f[p+1]);
	endfunction : frame_bad

	function automatic logic parity_bad(input uhtp_frame_t f, input uhtp_parity_t par);
		return (par != PAR_NONE) && (f[DATA_BITS+1] != par_bit(f[DATA_BITS:1], par));
	endfunction : parity_bad
endpackage : uhtp_pkg
